// ==== hdl/hsd_consts.svh ====
// Purpose: shared constants of the sa/ds0 packet controller
// Assumes: 8-bit register port, 8-bit data
// Notes:   offsets, bit positions, reset values and fixed patterns
`ifndef HSD_CONSTS_SVH
`define HSD_CONSTS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define HSD_ADR_CTRL    8'hB0
`define HSD_ADR_STAT    8'hB1
`define HSD_ADR_MASK    8'hB2
`define HSD_ADR_RXINFO  8'hB3
`define HSD_ADR_TXINFO  8'hB4
`define HSD_ADR_RXFIFO  8'hB5
`define HSD_ADR_TXFIFO  8'hB6
`define HSD_ADR_MODE    8'hB7

// ----------------------------------------------------------------
// control register bits
// ----------------------------------------------------------------
`define HSD_CTL_RXRST   6
`define HSD_CTL_IDLESEL 5
`define HSD_CTL_TXRST   4
`define HSD_CTL_ABORT   3
`define HSD_CTL_EOM     2
`define HSD_CTL_NOSTUFF 1
`define HSD_CTL_NOCRC   0
`define HSD_CTL_RST     8'h00
`define HSD_MASK_RST    8'h00
`define HSD_MODE_RST    8'h00

// ----------------------------------------------------------------
// latched positions of the three status registers
// ----------------------------------------------------------------
`define HSD_LAT_STAT    8'h61
`define HSD_LAT_RXINFO  8'hF0
`define HSD_LAT_TXINFO  8'h04

// ----------------------------------------------------------------
// line patterns and check sequence
// ----------------------------------------------------------------
`define HSD_FLAG        8'h7E
`define HSD_IDLE        8'hFF
`define HSD_ABORT       8'hFE
`define HSD_CRC_INIT    16'hFFFF
`define HSD_CRC_POLY    16'h8408
`define HSD_CRC_GOOD    16'hF0B8
`define HSD_FIFO_DEPTH  64

`endif

// ==== hdl/hsd_pkg.sv ====
// Purpose: types of the sa/ds0 packet controller
// Assumes: nothing
// Notes:   constants live in hsd_consts.svh
package hsd_pkg;
  // transmit sequencer states
  typedef enum logic [2:0] {
    TX_IDLE, TX_OPEN, TX_DATA, TX_CRC1, TX_CRC2, TX_CLOSE, TX_ABORT
  } hsd_tx_state_t;
endpackage

// ==== hdl/hsd_fifo.sv ====
// Purpose: show-ahead byte fifo with flush and fill level
// Assumes: single clock, a push when full is dropped
// Notes:   head word is visible without a pop
`timescale 1ns/10ps
module hsd_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 64
) (
  input  wire logic                       ref_clk_i,
  input  wire logic                       rst_b_i,
  input  wire logic                       flush_i,
  input  wire logic                       push_i,
  input  wire logic [W-1:0]               wdata_i,
  input  wire logic                       pop_i,
  output logic      [W-1:0]               rdata_o,
  output logic                            empty_o,
  output logic                            full_o,
  output logic      [$clog2(DEPTH):0]     level_o
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0]  mem [DEPTH];   // storage
  logic [AW-1:0] wp_reg;        // write pointer
  logic [AW-1:0] rp_reg;        // read pointer
  logic [AW:0]   lvl_reg;       // bytes held

  wire do_push = push_i && !full_o;
  wire do_pop  = pop_i && !empty_o;

  assign rdata_o = mem[rp_reg];
  assign empty_o = (lvl_reg == '0);
  assign full_o  = (lvl_reg == (AW+1)'(DEPTH));
  assign level_o = lvl_reg;

  // ----------------------------------------------------------------
  // pointers: one byte per push or pop
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i || flush_i) begin
      wp_reg  <= '0;
      rp_reg  <= '0;
      lvl_reg <= '0;
    end else begin
      if (do_push) begin
        wp_reg <= wp_reg + 1'b1;
      end
      if (do_pop) begin
        rp_reg <= rp_reg + 1'b1;
      end
      lvl_reg <= lvl_reg + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end

  // storage has no reset, contents are don't-care until written
  always_ff @(posedge ref_clk_i) begin
    if (do_push) begin
      mem[wp_reg] <= wdata_i;
    end
  end
endmodule

// ==== hdl/hsd_ctrl.sv ====
// Purpose: packet controller carried in sa bits or ds0 slots
// Assumes: slot strobes and serial data come from framer logic on ref_clk_i
// Notes:   register port, flags, check sequence, stuffing, aborts
//
// Functional notes
// - separate 64-byte transmit and receive buffers
// - insert/detect flags, generate/check CRC
// - aborts, zero stuffing, byte alignment
// - carry data in sa bits or slots
// - latched bit holds until a one is written to it
// - real-time bits live, writes ignored
// - written one captures copy, clears latch
// - written zero keeps readable copy
// - each event in the STAT register individually maskable
// - unmasked event pulls interrupt low
// - interrupt releases after host reads event
// - end-of-message bit self-clears after last byte
// - abort edge flushes, sends abort, idles
// - packet end/start, message end latched
//
// The register addresses and the strobed register port were chosen for this implementation.
`timescale 1ns/10ps
`include "hsd_consts.svh"
module hsd_ctrl #(
  parameter int DEPTH = `HSD_FIFO_DEPTH
) (
  input  wire logic       ref_clk_i,
  input  wire logic       rst_b_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wr_data_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rd_data_o,
  input  wire logic       tx_sa_slot_i,
  input  wire logic       tx_ds0_slot_i,
  output logic            tx_data_o,
  input  wire logic       rx_sa_slot_i,
  input  wire logic       rx_ds0_slot_i,
  input  wire logic       rx_data_i,
  input  wire logic       carrier_loss_i,
  input  wire logic       framer_irq_i,
  output logic            int_b_o
);
  localparam int LW = $clog2(DEPTH) + 1;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // one-hot select of the three status registers
  function automatic logic [2:0] stat_sel(input logic [7:0] a);
    return {a == `HSD_ADR_TXINFO, a == `HSD_ADR_RXINFO, a == `HSD_ADR_STAT};
  endfunction

  // one bit of the reflected check sequence
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
    return (c >> 1) ^ ((c[0] ^ b) ? `HSD_CRC_POLY : 16'h0000);
  endfunction

  // ----------------------------------------------------------------
  // register port decode
  // ----------------------------------------------------------------
  logic [7:0] ctrl_reg;            // control bits
  logic [7:0] controller_irq_mask_reg; // interrupt enables
  logic [7:0] mode_reg;            // bit0: 1 = slots, 0 = sa bits
  logic [7:0] rd_data_reg;         // read data, one cycle later
  logic       int_b_reg;           // shared interrupt, active low

  wire [2:0] wsel = wr_i ? stat_sel(addr_i) : 3'b000;
  wire [2:0] rsel = rd_i ? stat_sel(addr_i) : 3'b000;
  wire       ctl_wr  = wr_i && (addr_i == `HSD_ADR_CTRL);
  wire       msk_wr  = wr_i && (addr_i == `HSD_ADR_MASK);
  wire       mod_wr  = wr_i && (addr_i == `HSD_ADR_MODE);
  wire       txf_wr  = wr_i && (addr_i == `HSD_ADR_TXFIFO);
  wire       rxf_rd  = rd_i && (addr_i == `HSD_ADR_RXFIFO);

  // control bits acting on a 0-to-1 write
  wire rx_rst  = ctl_wr && wr_data_i[`HSD_CTL_RXRST] && !ctrl_reg[`HSD_CTL_RXRST];
  wire tx_rst  = ctl_wr && wr_data_i[`HSD_CTL_TXRST] && !ctrl_reg[`HSD_CTL_TXRST];
  wire abt_cmd = ctl_wr && wr_data_i[`HSD_CTL_ABORT] && !ctrl_reg[`HSD_CTL_ABORT];

  // ----------------------------------------------------------------
  // buffers
  // ----------------------------------------------------------------
  logic [8:0]    tf_q;     // {eom tag, byte}
  logic          tf_empty;
  logic          tf_full;
  logic [LW-1:0] tf_lvl;
  logic          tf_pop;
  logic [10:0]   rf_q;     // {ok, close, open, byte}
  logic [10:0]   rf_d;
  logic          rf_empty;
  logic          rf_full;
  logic [LW-1:0] rf_lvl;
  logic          rf_push;

  // two independent 64-byte buffers, one byte per access
  hsd_fifo #(.W(9), .DEPTH(DEPTH)) u_txf (
    .ref_clk_i (ref_clk_i),
    .rst_b_i   (rst_b_i),
    .flush_i   (tx_rst || abt_cmd),
    .push_i    (txf_wr),
    .wdata_i   ({ctrl_reg[`HSD_CTL_EOM], wr_data_i}),
    .pop_i     (tf_pop),
    .rdata_o   (tf_q),
    .empty_o   (tf_empty),
    .full_o    (tf_full),
    .level_o   (tf_lvl)
  );
  hsd_fifo #(.W(11), .DEPTH(DEPTH)) u_rxf (
    .ref_clk_i (ref_clk_i),
    .rst_b_i   (rst_b_i),
    .flush_i   (rx_rst),
    .push_i    (rf_push),
    .wdata_i   (rf_d),
    .pop_i     (rxf_rd),
    .rdata_o   (rf_q),
    .empty_o   (rf_empty),
    .full_o    (rf_full),
    .level_o   (rf_lvl)
  );

  // ----------------------------------------------------------------
  // transmit sequencer
  // ----------------------------------------------------------------
  hsd_pkg::hsd_tx_state_t tx_st_reg;   // current byte kind
  hsd_pkg::hsd_tx_state_t tx_st_next;
  logic [7:0]  tx_sh_reg;              // byte being shifted, lsb first
  logic [7:0]  tx_sh_next;
  logic [2:0]  tx_cnt_reg;             // bits sent of this byte
  logic [2:0]  tx_ones_reg;            // run of ones for stuffing
  logic [15:0] tx_crc_reg;             // running check sequence
  logic        tx_last_reg;            // current data byte is the last
  logic        tx_last_next;
  logic        tx_bit_reg;             // serial output
  logic        tx_udr;                 // underrun this byte
  logic        tx_eom_clr;             // last byte gone out

  // sa positions or selected slots carry the bits
  wire tx_en    = mode_reg[0] ? tx_ds0_slot_i : tx_sa_slot_i;
  wire tx_cnts  = (tx_st_reg == hsd_pkg::TX_DATA) || (tx_st_reg == hsd_pkg::TX_CRC1) ||
                  (tx_st_reg == hsd_pkg::TX_CRC2);
  // a stuffed zero also precedes a closing flag after five ones
  wire tx_stuff = (tx_ones_reg == 3'd5);
  wire tx_adv   = tx_en && !tx_stuff;
  wire tx_bdone = tx_adv && (tx_cnt_reg == 3'd7);
  wire [15:0] tx_crc_upd = (tx_adv && tx_st_reg == hsd_pkg::TX_DATA) ?
                           crc_step(tx_crc_reg, tx_sh_reg[0]) : tx_crc_reg;
  wire [7:0] idle_pat = ctrl_reg[`HSD_CTL_IDLESEL] ? `HSD_IDLE : `HSD_FLAG;

  // choice of the next byte at a byte boundary
  always_comb begin
    tx_st_next   = tx_st_reg;
    tx_sh_next   = idle_pat;
    tx_last_next = tx_last_reg;
    tf_pop       = 1'b0;
    tx_udr       = 1'b0;
    tx_eom_clr   = 1'b0;
    if (tx_bdone) begin
      unique case (tx_st_reg)
        hsd_pkg::TX_IDLE, hsd_pkg::TX_CLOSE, hsd_pkg::TX_ABORT: begin
          // opening flag as soon as data waits
          if (!tf_empty) begin
            tx_st_next = hsd_pkg::TX_OPEN;
            tx_sh_next = `HSD_FLAG;
          end else begin
            tx_st_next = hsd_pkg::TX_IDLE;
          end
        end
        hsd_pkg::TX_OPEN, hsd_pkg::TX_DATA: begin
          if (tx_st_reg == hsd_pkg::TX_DATA && tx_last_reg) begin
            tx_eom_clr = 1'b1;
            if (ctrl_reg[`HSD_CTL_NOCRC]) begin
              tx_st_next = hsd_pkg::TX_CLOSE;
              tx_sh_next = `HSD_FLAG;
            end else begin
              tx_st_next = hsd_pkg::TX_CRC1;
              tx_sh_next = ~tx_crc_upd[7:0];
            end
          end else if (!tf_empty) begin
            tx_st_next   = hsd_pkg::TX_DATA;
            tx_sh_next   = tf_q[7:0];
            tx_last_next = tf_q[8];
            tf_pop       = 1'b1;
          end else begin
            // starved mid-packet: abort it
            tx_st_next = hsd_pkg::TX_ABORT;
            tx_sh_next = `HSD_ABORT;
            tx_udr     = 1'b1;
          end
        end
        hsd_pkg::TX_CRC1: begin
          tx_st_next = hsd_pkg::TX_CRC2;
          tx_sh_next = ~tx_crc_reg[15:8];
        end
        hsd_pkg::TX_CRC2: begin
          tx_st_next = hsd_pkg::TX_CLOSE;
          tx_sh_next = `HSD_FLAG;
        end
      endcase
    end
  end

  // bit shifter and sequencer state
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i || tx_rst) begin
      tx_st_reg   <= hsd_pkg::TX_IDLE;
      tx_sh_reg   <= `HSD_FLAG;
      tx_cnt_reg  <= 3'd0;
      tx_ones_reg <= 3'd0;
      tx_crc_reg  <= `HSD_CRC_INIT;
      tx_last_reg <= 1'b0;
      tx_bit_reg  <= 1'b1;
    end else if (abt_cmd) begin
      // abort edge: drop the byte in flight, send one abort
      tx_st_reg   <= hsd_pkg::TX_ABORT;
      tx_sh_reg   <= `HSD_ABORT;
      tx_cnt_reg  <= 3'd0;
      tx_ones_reg <= 3'd0;
      tx_last_reg <= 1'b0;
    end else begin
      if (tx_en) begin
        tx_bit_reg <= tx_stuff ? 1'b0 : tx_sh_reg[0];
      end
      if (tx_en && tx_stuff) begin
        tx_ones_reg <= 3'd0;
      end else if (tx_adv) begin
        tx_ones_reg <= (tx_cnts && !ctrl_reg[`HSD_CTL_NOSTUFF] && tx_sh_reg[0]) ?
                       tx_ones_reg + 3'd1 : 3'd0;
      end
      if (tx_adv) begin
        tx_cnt_reg <= tx_cnt_reg + 3'd1;
        tx_sh_reg  <= tx_bdone ? tx_sh_next : {1'b0, tx_sh_reg[7:1]};
      end
      tx_crc_reg  <= (tx_bdone && tx_st_next == hsd_pkg::TX_OPEN) ?
                     `HSD_CRC_INIT : tx_crc_upd;
      tx_st_reg   <= tx_st_next;
      tx_last_reg <= tx_last_next;
    end
  end

  // ----------------------------------------------------------------
  // receive deframer
  // ----------------------------------------------------------------
  logic [2:0]  rx_ones_reg;   // run of ones, saturating
  logic        rx_inf_reg;    // opening flag seen
  logic [5:0]  rx_dq_reg;     // six-bit delay hides the flag prefix
  logic [2:0]  rx_dn_reg;     // bits held in delay
  logic [7:0]  rx_sh_reg;     // byte assembly
  logic [2:0]  rx_bc_reg;     // bit position in byte
  logic [15:0] rx_crc_reg;    // running check
  logic [7:0]  rx_h_reg [3];  // last three bytes, two are the check
  logic [1:0]  rx_nh_reg;     // bytes held
  logic        rx_first_reg;  // next pushed byte opens the packet
  logic        rx_any_reg;    // data bits since opening flag

  wire rx_en    = mode_reg[0] ? rx_ds0_slot_i : rx_sa_slot_i;
  wire rx_b     = rx_data_i;
  wire rx_flag  = rx_en && !rx_b && (rx_ones_reg == 3'd6);
  wire rx_abt   = rx_en && rx_b && (rx_ones_reg == 3'd6);
  wire rx_unst  = rx_en && !rx_b && (rx_ones_reg == 3'd5);
  wire rx_cand  = rx_en && rx_inf_reg && !rx_flag && !rx_unst &&
                  !(rx_b && rx_ones_reg >= 3'd5);
  wire rx_rel   = rx_cand && (rx_dn_reg == 3'd6);
  wire rx_rbit  = rx_dq_reg[0];
  wire rx_bdone = rx_rel && (rx_bc_reg == 3'd7);
  wire [7:0] rx_byte = {rx_rbit, rx_sh_reg[7:1]};
  wire rx_close = rx_flag && rx_inf_reg && rx_any_reg;
  wire rx_good  = (rx_crc_reg == `HSD_CRC_GOOD) && (rx_bc_reg == 3'd0) &&
                  (rx_nh_reg == 2'd3);
  wire rx_full3 = (rx_nh_reg == 2'd3);

  // push the oldest held byte on a new byte or on a good-length close
  assign rf_push = (rx_bdone && rx_full3) || (rx_close && rx_full3);
  assign rf_d    = {rx_close && rx_good, rx_close, rx_first_reg, rx_h_reg[0]};

  // events toward the status registers
  wire ev_rps  = rx_bdone && rx_first_reg && (rx_nh_reg == 2'd0);
  wire ev_rovr = rf_push && rf_full;
  wire ev_rx_abort_seen = rx_abt;
  wire ev_rpe  = rx_close || (rx_abt && rx_inf_reg && rx_any_reg) || ev_rovr;
  wire ev_rvm  = rx_close && rx_good;
  wire ev_rcrc = rx_close && !rx_good;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i || rx_rst) begin
      rx_ones_reg  <= 3'd0;
      rx_inf_reg   <= 1'b0;
      rx_dq_reg    <= 6'h00;
      rx_dn_reg    <= 3'd0;
      rx_sh_reg    <= 8'h00;
      rx_bc_reg    <= 3'd0;
      rx_crc_reg   <= `HSD_CRC_INIT;
      rx_nh_reg    <= 2'd0;
      rx_first_reg <= 1'b1;
      rx_any_reg   <= 1'b0;
      rx_h_reg     <= '{8'h00, 8'h00, 8'h00};
    end else begin
      if (rx_en) begin
        rx_ones_reg <= !rx_b ? 3'd0 :
                       (rx_ones_reg == 3'd7) ? 3'd7 : rx_ones_reg + 3'd1;
      end
      if (rx_flag || rx_abt) begin
        // a flag opens the next packet, an abort waits for a flag
        rx_inf_reg   <= rx_flag;
        rx_dn_reg    <= 3'd0;
        rx_bc_reg    <= 3'd0;
        rx_crc_reg   <= `HSD_CRC_INIT;
        rx_nh_reg    <= 2'd0;
        rx_first_reg <= 1'b1;
        rx_any_reg   <= 1'b0;
      end else if (rx_cand) begin
        rx_dq_reg <= {rx_b, rx_dq_reg[5:1]};
        if (!rx_rel) begin
          rx_dn_reg <= rx_dn_reg + 3'd1;
        end else begin
          rx_any_reg <= 1'b1;
          rx_sh_reg  <= rx_byte;
          rx_bc_reg  <= rx_bc_reg + 3'd1;
          rx_crc_reg <= crc_step(rx_crc_reg, rx_rbit);
        end
        if (rx_bdone && rx_full3) begin
          rx_h_reg     <= '{rx_h_reg[1], rx_h_reg[2], rx_byte};
          rx_first_reg <= 1'b0;
        end else if (rx_bdone) begin
          rx_h_reg[rx_nh_reg] <= rx_byte;
          rx_nh_reg           <= rx_nh_reg + 2'd1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // status registers: latched, real-time, readable copy
  // ----------------------------------------------------------------
  logic [7:0] ev_reg   [3];   // latched events not yet captured
  logic [7:0] copy_reg [3];   // readable copy of latched bits
  logic [7:0] pend_reg [3];   // captured but not yet read
  logic [7:0] ev_set   [3];
  logic [7:0] rt_val   [3];
  logic [7:0] lmask    [3];
  logic [7:0] st_rd    [3];

  // latched: packet end, packet start, message end; abort, crc error, overrun, valid message; underrun
  assign ev_set[0] = {1'b0, ev_rpe, ev_rps, 4'h0, tx_bdone && tx_st_reg == hsd_pkg::TX_CLOSE};
  assign ev_set[1] = {ev_rx_abort_seen, ev_rcrc, ev_rovr, ev_rvm, 4'h0};
  assign ev_set[2] = {5'h00, tx_udr, 2'b00};
  // real-time levels
  assign rt_val[0] = {carrier_loss_i, 2'b00, rf_lvl > LW'(DEPTH / 2), !rf_empty,
                      tf_lvl < LW'(DEPTH / 2), !tf_full, 1'b0};
  assign rt_val[1] = {4'h0, rf_empty, rf_q[10:8]};
  assign rt_val[2] = {6'h00, tf_full, tf_empty};
  assign lmask[0]  = `HSD_LAT_STAT;
  assign lmask[1]  = `HSD_LAT_RXINFO;
  assign lmask[2]  = `HSD_LAT_TXINFO;

  for (genvar i = 0; i < 3; i++) begin : g_stat
    wire [7:0] wm = wsel[i] ? (wr_data_i & lmask[i]) : 8'h00;
    assign st_rd[i] = (copy_reg[i] & lmask[i]) | (rt_val[i] & ~lmask[i]);

    // write-then-read capture; a new event beats the clear
    always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
        ev_reg[i]   <= 8'h00;
        copy_reg[i] <= 8'h00;
        pend_reg[i] <= 8'h00;
      end else begin
        ev_reg[i]   <= (ev_reg[i] & ~wm) | ev_set[i];
        copy_reg[i] <= (copy_reg[i] & ~wm) | (ev_reg[i] & wm);
        pend_reg[i] <= rsel[i] ? 8'h00 : (pend_reg[i] | (ev_reg[i] & wm));
      end
    end
  end

  // interrupt sources: uncaptured or unread latched, live real-time
  wire [7:0] irq_src = ((ev_reg[0] | pend_reg[0]) & lmask[0]) | (rt_val[0] & ~lmask[0]);

  // ----------------------------------------------------------------
  // control, mask, mode, read data and interrupt
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      ctrl_reg                <= `HSD_CTL_RST;
      controller_irq_mask_reg <= `HSD_MASK_RST;
      mode_reg                <= `HSD_MODE_RST;
      int_b_reg               <= 1'b1;
    end else begin
      if (ctl_wr) begin
        ctrl_reg <= wr_data_i & 8'h7F;
      end else if (tx_eom_clr || tx_rst) begin
        ctrl_reg[`HSD_CTL_EOM] <= 1'b0;
      end
      if (msk_wr) begin
        controller_irq_mask_reg <= wr_data_i;
      end
      if (mod_wr) begin
        mode_reg <= wr_data_i & 8'h01;
      end
      // masked sources joined with the framer's own
      int_b_reg <= !(|(irq_src & controller_irq_mask_reg) || framer_irq_i);
    end
  end

  // read data valid the cycle after the strobe, zero when unmapped
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      rd_data_reg <= 8'h00;
    end else if (rd_i) begin
      unique case (addr_i)
        `HSD_ADR_CTRL:   rd_data_reg <= ctrl_reg;
        `HSD_ADR_STAT:   rd_data_reg <= st_rd[0];
        `HSD_ADR_MASK:   rd_data_reg <= controller_irq_mask_reg;
        `HSD_ADR_RXINFO: rd_data_reg <= st_rd[1];
        `HSD_ADR_TXINFO: rd_data_reg <= st_rd[2];
        `HSD_ADR_RXFIFO: rd_data_reg <= rf_empty ? 8'h00 : rf_q[7:0];
        `HSD_ADR_MODE:   rd_data_reg <= mode_reg;
        default:         rd_data_reg <= 8'h00;
      endcase
    end
  end

  assign rd_data_o = rd_data_reg;
  assign tx_data_o = tx_bit_reg;
  assign int_b_o   = int_b_reg;
endmodule

// ==== bench/hsd_monitor.sv ====
// Purpose: port-level checks of the packet controller
// Assumes: sa strobes carry the link, idle select left at 7E
// Notes:   bound onto hsd_ctrl below
`timescale 1ns/10ps
`include "hsd_consts.svh"
module hsd_monitor (
  input wire logic       ref_clk_i,
  input wire logic       rst_b_i,
  input wire logic [7:0] addr_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic [7:0] rd_data_o,
  input wire logic       tx_sa_slot_i,
  input wire logic       tx_data_o,
  input wire logic       carrier_loss_i,
  input wire logic       framer_irq_i,
  input wire logic       int_b_o
);
  // ------------------------------------------------------------
  // helper logic and properties
  // ------------------------------------------------------------
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  logic [3:0] ones_reg;  // run of ones seen at the bit strobes
  // abort is the longest legal run, seven ones
  always_ff @(posedge ref_clk_i)
    if (!rst_b_i) ones_reg <= 4'h0;
    else if (tx_sa_slot_i) ones_reg <= tx_data_o ? ones_reg + 4'h1 : 4'h0;
  sequence s_rd_stat; rd_i && addr_i == `HSD_ADR_STAT; endsequence
  property p_irq_share; framer_irq_i [*3] |-> !int_b_o; endproperty
  property p_irq_fast; $rose(framer_irq_i) |-> ##[1:2] !int_b_o; endproperty
  property p_no_rise; $past(framer_irq_i) && $past(framer_irq_i, 2) |-> !$rose(int_b_o);
  endproperty
  property p_live; s_rd_stat ##0 $stable(carrier_loss_i) ##1 $stable(carrier_loss_i)
    |-> rd_data_o[7] == carrier_loss_i; endproperty
  property p_hold; s_rd_stat ##1 !wr_i ##1 s_rd_stat
    |=> (rd_data_o & 8'h61) == ($past(rd_data_o, 2) & 8'h61); endproperty
  property p_tx_slot; !$stable(tx_data_o) |-> $past(tx_sa_slot_i); endproperty
  property p_run; ones_reg <= 4'h7; endproperty
  property p_unmapped; rd_i && addr_i < 8'hB0 |=> rd_data_o == 8'h00; endproperty
  a_irq_share: assert property (p_irq_share) else $error("int not low for framer");
  a_irq_fast: assert property (p_irq_fast) else $error("int late");
  a_no_rise: assert property (p_no_rise) else $error("int released early");
  a_live: assert property (p_live) else $error("live bit wrong");
  a_hold: assert property (p_hold) else $error("latched copy moved");
  a_tx_slot: assert property (p_tx_slot) else $error("line moved off slot");
  a_run: assert property (p_run) else $error("ones run too long");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule
bind hsd_ctrl hsd_monitor u_mon (.ref_clk_i, .rst_b_i, .addr_i, .wr_i, .rd_i, .rd_data_o,
  .tx_sa_slot_i, .tx_data_o, .carrier_loss_i, .framer_irq_i, .int_b_o);

// ==== bench/hsd_link_model.sv ====
// Purpose: far end of the link, loops transmit into receive
// Assumes: one bit slot every four clocks
// Notes:   en_i low stops every strobe
`timescale 1ns/10ps
module hsd_link_model (
  input  wire logic ref_clk_i,
  input  wire logic rst_b_i,
  input  wire logic en_i,
  input  wire logic tx_data_i,
  output logic      tx_slot_o,
  output logic      rx_slot_o,
  output logic      rx_data_o
);
  // ------------------------------------------------------------
  // rx strobe one clock late sees the new bit
  // ------------------------------------------------------------
  logic [1:0] div_reg;  // slot divider
  always_ff @(posedge ref_clk_i) begin
    div_reg   <= rst_b_i ? div_reg + 2'h1 : 2'h0;
    rx_slot_o <= tx_slot_o;
  end
  assign tx_slot_o = en_i && div_reg == 2'h3;
  assign rx_data_o = tx_data_i;
endmodule

// ==== bench/testbench.sv ====
// Purpose: register-level regression of the packet controller
// Assumes: serial line looped back by the link model
// Notes:   polls are bounded, a watchdog ends a hang
`timescale 1ns/10ps
`include "hsd_consts.svh"
module testbench;
  // ------------------------------------------------------------
  // signals, instances, tasks
  // ------------------------------------------------------------
  logic       ref_clk_i = 1'b0, rst_b_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, link_en = 1'b1;
  logic       carrier_loss_i = 1'b0, framer_irq_i = 1'b0, tx_slot, rx_slot, rx_data;
  logic       tx_data_o, int_b_o;
  logic [7:0] addr_i = 8'h00, wr_data_i = 8'h00, rd_data_o, rd_v;
  int         n_errors = 0, check_count = 0;
  initial forever #12.5 ref_clk_i = ~ref_clk_i;
  hsd_ctrl u_dut (.ref_clk_i, .rst_b_i, .addr_i, .wr_data_i, .wr_i, .rd_i, .rd_data_o,
    .tx_sa_slot_i(tx_slot), .tx_ds0_slot_i(1'b0), .tx_data_o, .rx_sa_slot_i(rx_slot),
    .rx_ds0_slot_i(1'b0), .rx_data_i(rx_data), .carrier_loss_i, .framer_irq_i, .int_b_o);
  hsd_link_model u_link (.ref_clk_i, .rst_b_i, .en_i(link_en),
    .tx_data_i(tx_data_o), .tx_slot_o(tx_slot), .rx_slot_o(rx_slot), .rx_data_o(rx_data));
  task automatic wr(input logic [7:0] a, d);
    @(posedge ref_clk_i);
    {wr_i, addr_i, wr_data_i} <= {1'b1, a, d};
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic chk(input string n, input logic [7:0] e, g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  // read, data taken the cycle after
  task automatic rchk(input logic [7:0] a, m, e, input string n);
    @(posedge ref_clk_i);
    {rd_i, addr_i} <= {1'b1, a};
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    @(negedge ref_clk_i);
    rd_v = rd_data_o;
    if (n != "") chk(n, e, rd_v & m);
  endtask
  // write mask, read back until set
  task automatic poll(input logic [7:0] a, input logic [7:0] m);
    rd_v = 8'h00;
    for (int i = 0; i < 300 && (rd_v & m) !== m; i++) begin
      wr(a, m);
      rchk(a, m, m, "");
    end
    chk("poll", m, rd_v & m);
  endtask
  // framer request at a rising edge, interrupt pin sampled settled
  task automatic ichk(input string n, input logic e, f);
    @(posedge ref_clk_i);
    framer_irq_i <= f;
    repeat (3) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    chk(n, {7'h00, e}, {7'h00, int_b_o});
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    repeat (16) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    rchk(`HSD_ADR_CTRL, 8'hFF, `HSD_CTL_RST, "ctrl");
    rchk(`HSD_ADR_MASK, 8'hFF, `HSD_MASK_RST, "mask");
    rchk(8'h10, 8'hFF, 8'h00, "unmapped");
    rchk(`HSD_ADR_TXINFO, 8'h01, 8'h01, "tx empty");
    wr(`HSD_ADR_TXFIFO, 8'hFF);
    wr(`HSD_ADR_TXFIFO, 8'h7E);
    wr(`HSD_ADR_CTRL, 8'h04);
    wr(`HSD_ADR_TXFIFO, 8'h0F);
    poll(`HSD_ADR_STAT, 8'h01);
    wr(`HSD_ADR_TXINFO, 8'h04);
    rchk(`HSD_ADR_TXINFO, 8'h04, 8'h00, "underrun");
    poll(`HSD_ADR_STAT, 8'h40);
    rchk(`HSD_ADR_CTRL, 8'h04, 8'h00, "eom");
    wr(`HSD_ADR_STAT, 8'h00);
    rchk(`HSD_ADR_STAT, 8'h40, 8'h40, "copy kept");
    wr(`HSD_ADR_STAT, 8'h40);
    rchk(`HSD_ADR_STAT, 8'h40, 8'h00, "cleared");
    rchk(`HSD_ADR_STAT, 8'h40, 8'h00, "stays");
    rchk(`HSD_ADR_RXINFO, 8'h0B, 8'h01, "head open");
    rchk(`HSD_ADR_RXFIFO, 8'hFF, 8'hFF, "byte0");
    rchk(`HSD_ADR_RXFIFO, 8'hFF, 8'h7E, "byte1");
    rchk(`HSD_ADR_RXINFO, 8'h0F, 8'h06, "head close");
    rchk(`HSD_ADR_RXFIFO, 8'hFF, 8'h0F, "byte2");
    rchk(`HSD_ADR_RXFIFO, 8'hFF, 8'h00, "empty read");
    $display("test packet done");
    link_en <= 1'b0;
    for (int i = 0; i < 65; i++) wr(`HSD_ADR_TXFIFO, 8'(i));
    rchk(`HSD_ADR_TXINFO, 8'h03, 8'h02, "tx full");
    rchk(`HSD_ADR_STAT, 8'h02, 8'h00, "not full");
    wr(`HSD_ADR_CTRL, 8'h08);
    rchk(`HSD_ADR_TXINFO, 8'h03, 8'h01, "flushed");
    link_en <= 1'b1;
    $display("test fill done");
    wr(`HSD_ADR_MASK, 8'h80);
    carrier_loss_i <= 1'b1;
    rchk(`HSD_ADR_STAT, 8'h80, 8'h80, "carrier");
    ichk("int low", 1'b0, 1'b0);
    wr(`HSD_ADR_MASK, 8'h00);
    ichk("int masked", 1'b1, 1'b0);
    ichk("int shared", 1'b0, 1'b1);
    ichk("int high", 1'b1, 1'b0);
    $display("test irq done");
    final_report;
  end
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    n_errors++;
    final_report;
  end
endmodule
